// [core/ssr_pkg.sv]
// shared constants and types of the sync serial receive path
package ssr_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CLKDIV = 8'h04;
   localparam logic [7:0] OFF_RXCLK = 8'h10;
   localparam logic [7:0] OFF_RXFRM = 8'h14;
   localparam logic [7:0] OFF_SYNCHOLD = 8'h30;
   localparam logic [7:0] OFF_CTRL = 8'h50;
   localparam logic [7:0] OFF_STATUS = 8'h54;
   // reset value of each register and writable bits of the clock, frame and control registers
   localparam logic [31:0] REG_RESET = 32'h00000000;
   localparam logic [31:0] MASK_CLKDIV = 32'h00000FFF;
   localparam logic [31:0] MASK_RXCLK = 32'hFFFF1FFF;
   localparam logic [31:0] MASK_RXFRM = 32'hF17F0FBF;
   localparam logic [31:0] MASK_CTRL = 32'h00000001;
   // field positions
   localparam int DIV_LSB = 0;
   localparam int PERIOD_LSB = 24;
   localparam int DLY_LSB = 16;
   localparam int STOP_BIT = 12;
   localparam int START_LSB = 8;
   localparam int GATE_LSB = 6;
   localparam int INV_BIT = 5;
   localparam int CKOUT_LSB = 2;
   localparam int CKSRC_LSB = 0;
   localparam int SLH_LSB = 28;
   localparam int EDGE_BIT = 24;
   localparam int SOUT_LSB = 20;
   localparam int SLL_LSB = 16;
   localparam int WPF_LSB = 8;
   localparam int ORDER_BIT = 7;
   localparam int LOOP_BIT = 5;
   localparam int WLEN_LSB = 0;
   localparam int EN_BIT = 0;
   // start condition codes
   localparam logic [3:0] START_CONT = 4'h0;
   localparam logic [3:0] START_TX = 4'h1;
   localparam logic [3:0] START_LOW = 4'h2;
   localparam logic [3:0] START_HIGH = 4'h3;
   localparam logic [3:0] START_FALL = 4'h4;
   localparam logic [3:0] START_RISE = 4'h5;
   localparam logic [3:0] START_LEVEL = 4'h6;
   localparam logic [3:0] START_EDGE = 4'h7;
   localparam logic [3:0] START_CMP0 = 4'h8;
   // clock source, gating, clock pin and sync pin codes
   localparam logic [1:0] SRC_DIV = 2'h0;
   localparam logic [1:0] SRC_TX = 2'h1;
   localparam logic [1:0] SRC_PIN = 2'h2;
   localparam logic [1:0] GATE_NONE = 2'h0;
   localparam logic [1:0] GATE_LOW = 2'h1;
   localparam logic [1:0] GATE_HIGH = 2'h2;
   localparam logic [2:0] CKOUT_CONT = 3'h1;
   localparam logic [2:0] CKOUT_XFER = 3'h2;
   localparam logic [2:0] SOUT_NEG = 3'h1;
   localparam logic [2:0] SOUT_POS = 3'h2;
   localparam logic [2:0] SOUT_LOW = 3'h3;
   localparam logic [2:0] SOUT_HIGH = 3'h4;
   localparam logic [2:0] SOUT_TOGGLE = 3'h5;
   // receiver sequencing
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DELAY = 2'b01,
      ST_DATA = 2'b10
   } ssr_state_e;
endpackage

// [core/ssr_clk_div.sv]
// divided bit clock generator
`timescale 1ns/1ps
module ssr_clk_div #(
   parameter int W = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // divider setting and divided clock level
   input wire logic [W-1:0] div,
   output logic div_clk
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic lvl;
   } ssr_div_s;

   ssr_div_s r;
   ssr_div_s n;

   // half period of div clocks, so the divided clock is clk / (2 * div)
   always_comb begin
      n = r;
      if (div == '0) begin
         n.cnt = '0;
         n.lvl = 1'b0;
      end else if (r.cnt >= div - W'(1)) begin
         n.cnt = '0; // >= keeps a shrunken divider from running away
         n.lvl = ~r.lvl;
      end else begin
         n.cnt = r.cnt + W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign div_clk = r.lvl;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   div_off_a: assert property (div == '0 |=> !div_clk)
      else $error("divided clock runs with divider at zero");
   div_toggle_a: assert property ($changed(div_clk) |->
      $past(div) == '0 || $past(r.cnt) >= $past(div) - W'(1))
      else $error("divided clock toggled before its half period");
   div_fast_a: assert property (div == W'(1) && $past(div) == W'(1)
      && !$past(rst) |-> $changed(div_clk))
      else $error("divider of one does not give half the clock");
endmodule

// [core/ssr_start_sel.sv]
// start condition decoder for the receiver
`timescale 1ns/1ps
module ssr_start_sel (
   // start code and conditions seen at a sampling edge
   input wire logic [3:0] code,
   input wire logic sync_now,
   input wire logic sync_prev,
   input wire logic tx_pend,
   input wire logic cmp0_hit,
   // start event
   output logic hit
);
   // levels and edges are judged on sampled frame sync values
   always_comb begin
      case (code)
         ssr_pkg::START_CONT: hit = 1'b1;
         ssr_pkg::START_TX: hit = tx_pend;
         ssr_pkg::START_LOW: hit = ~sync_now;
         ssr_pkg::START_HIGH: hit = sync_now;
         ssr_pkg::START_FALL: hit = sync_prev & ~sync_now;
         ssr_pkg::START_RISE: hit = ~sync_prev & sync_now;
         ssr_pkg::START_LEVEL: hit = sync_prev ^ sync_now;
         ssr_pkg::START_EDGE: hit = sync_prev ^ sync_now;
         ssr_pkg::START_CMP0: hit = cmp0_hit;
         default: hit = 1'b0;
      endcase
   end
endmodule

// [core/ssr_rx_core.sv]
// receive clock, frame and word path of the sync serial controller
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module ssr_rx_core #(
   parameter int SW = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // receive clock pin
   input wire logic rx_clk_pin,
   output logic rx_clk_drv,
   output logic rx_clk_oe,
   // receive frame sync pin
   input wire logic rx_sync_pin,
   output logic rx_sync_drv,
   output logic rx_sync_oe,
   // receive data pin
   input wire logic rx_data,
   // transmitter side signals
   input wire logic tx_clk,
   input wire logic tx_sync,
   input wire logic tx_data,
   input wire logic tx_start,
   // compare patterns
   input wire logic [SW-1:0] cmp0,
   input wire logic [SW-1:0] cmp1,
   // received words
   output logic [31:0] rx_word,
   output logic rx_word_valid
);
   typedef struct packed {
      logic [31:0] clkdiv;
      logic [31:0] rxclk;
      logic [31:0] rxfrm;
      logic enable;
      logic sync_flag;
      logic prev_clk;
      logic sync_q;
      logic sync_p;
      logic tx_pend;
      logic [SW-1:0] hunt;
      logic [SW-1:0] sync_hold;
      ssr_pkg::ssr_state_e st;
      logic [7:0] dly;
      logic [4:0] bit_cnt;
      logic [3:0] word_cnt;
      logic [31:0] shreg;
      logic [31:0] word;
      logic word_valid;
      logic cmp1_seen;
      logic [8:0] per_cnt;
      logic pulse_req;
      logic pulse_on;
      logic [7:0] pulse_cnt;
      logic toggle;
      logic sync_o;
      logic sync_oe;
      logic clk_o;
      logic clk_oe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ssr_core_s;

   ssr_core_s r;
   ssr_core_s n;

   // configuration fields
   logic [7:0] period;
   logic [7:0] start_delay;
   logic stop_sel;
   logic [3:0] start_sel;
   logic [1:0] clock_gating_select;
   logic clock_inversion;
   logic [2:0] clock_output_select;
   logic [1:0] clock_source_select;
   logic [7:0] sync_length;
   logic sync_edge_select;
   logic [2:0] sync_output_select;
   logic [3:0] words_per_frame;
   logic bit_order;
   logic loop_sel;
   logic [4:0] word_length;
   logic div_clk;
   logic [SW-1:0] cmp_mask;
   logic [31:0] rd;
   logic addr_ok;
   logic go;
   logic [SW-1:0] hunt_n;
   logic cmp0_hit;
   logic cmp1_hit;
   logic din;
   logic sync_in;
   logic src_clk;
   logic gate_ok;
   logic gclk;
   logic s_edge;
   logic d_edge;

   assign period = r.rxclk[ssr_pkg::PERIOD_LSB +: 8];
   assign start_delay = r.rxclk[ssr_pkg::DLY_LSB +: 8];
   assign stop_sel = r.rxclk[ssr_pkg::STOP_BIT];
   assign start_sel = r.rxclk[ssr_pkg::START_LSB +: 4];
   assign clock_gating_select = r.rxclk[ssr_pkg::GATE_LSB +: 2];
   assign clock_inversion = r.rxclk[ssr_pkg::INV_BIT];
   assign clock_output_select = r.rxclk[ssr_pkg::CKOUT_LSB +: 3];
   assign clock_source_select = r.rxclk[ssr_pkg::CKSRC_LSB +: 2];
   assign sync_length = {r.rxfrm[ssr_pkg::SLH_LSB +: 4],
                         r.rxfrm[ssr_pkg::SLL_LSB +: 4]};
   assign sync_edge_select = r.rxfrm[ssr_pkg::EDGE_BIT];
   assign sync_output_select = r.rxfrm[ssr_pkg::SOUT_LSB +: 3];
   assign words_per_frame = r.rxfrm[ssr_pkg::WPF_LSB +: 4];
   assign bit_order = r.rxfrm[ssr_pkg::ORDER_BIT];
   assign loop_sel = r.rxfrm[ssr_pkg::LOOP_BIT];
   assign word_length = r.rxfrm[ssr_pkg::WLEN_LSB +: 5];

   ssr_clk_div #(
      .W(12)
   ) u_div (
      .clk(clk),
      .rst(rst),
      .div(r.clkdiv[ssr_pkg::DIV_LSB +: 12]),
      .div_clk(div_clk)
   );

   // bits beyond the sync length take no part in holding or compare
   for (genvar g = 0; g < SW; g++) begin : g_mask
      assign cmp_mask[g] = (sync_length >= 8'(g));
   end

   // loop mode takes sync and data from the transmitter, and its clock in place of the clock pin
   always_comb begin
      din = loop_sel ? tx_data : rx_data;
      sync_in = loop_sel ? tx_sync : rx_sync_pin;
      case (clock_source_select)
         ssr_pkg::SRC_DIV: src_clk = div_clk;
         ssr_pkg::SRC_TX: src_clk = tx_clk;
         ssr_pkg::SRC_PIN: src_clk = loop_sel ? tx_clk : rx_clk_pin;
         default: src_clk = 1'b0;
      endcase
      case (clock_gating_select)
         ssr_pkg::GATE_NONE: gate_ok = 1'b1;
         ssr_pkg::GATE_LOW: gate_ok = ~sync_in;
         ssr_pkg::GATE_HIGH: gate_ok = sync_in;
         default: gate_ok = 1'b0;
      endcase
      gclk = src_clk & gate_ok;
      // sampling and driving edges swap with inversion
      s_edge = clock_inversion ? (gclk & ~r.prev_clk) : (~gclk & r.prev_clk);
      d_edge = clock_inversion ? (~gclk & r.prev_clk) : (gclk & ~r.prev_clk);
      hunt_n = {r.hunt[SW-2:0], din};
      cmp0_hit = ((hunt_n ^ cmp0) & cmp_mask) == '0;
      cmp1_hit = ((hunt_n ^ cmp1) & cmp_mask) == '0;
   end

   ssr_start_sel u_start (
      .code(start_sel),
      .sync_now(sync_in),
      .sync_prev(r.sync_q),
      .tx_pend(r.tx_pend),
      .cmp0_hit(cmp0_hit),
      .hit(go)
   );

   // register read decode; anything else is answered with an error
   always_comb begin
      rd = ssr_pkg::REG_RESET;
      addr_ok = 1'b1;
      case (paddr)
         ssr_pkg::OFF_CLKDIV: rd = r.clkdiv;
         ssr_pkg::OFF_RXCLK: rd = r.rxclk;
         ssr_pkg::OFF_RXFRM: rd = r.rxfrm;
         ssr_pkg::OFF_SYNCHOLD: rd = 32'(r.sync_hold);
         ssr_pkg::OFF_CTRL: rd = 32'(r.enable);
         ssr_pkg::OFF_STATUS: rd = {30'h00000000, r.sync_flag, r.st != ssr_pkg::ST_IDLE};
         default: addr_ok = 1'b0;
      endcase
   end

   // whole next state of the block
   always_comb begin
      n = r;
      n.word_valid = 1'b0;
      // apb: one wait state so that read data comes from a flop
      n.pready = psel & penable & ~r.pready;
      if (psel && penable && !r.pready) begin
         n.prdata = rd;
         n.pslverr = ~addr_ok;
      end
      if (psel && penable && r.pready && pwrite && addr_ok) begin
         case (paddr)
            ssr_pkg::OFF_CLKDIV: n.clkdiv = pwdata & ssr_pkg::MASK_CLKDIV;
            ssr_pkg::OFF_RXCLK: n.rxclk = pwdata & ssr_pkg::MASK_RXCLK;
            ssr_pkg::OFF_RXFRM: n.rxfrm = pwdata & ssr_pkg::MASK_RXFRM;
            ssr_pkg::OFF_CTRL: n.enable = pwdata[ssr_pkg::EN_BIT];
            ssr_pkg::OFF_STATUS: n.sync_flag = r.sync_flag & ~pwdata[1];
            default: n.enable = r.enable;
         endcase
      end
      // clock pin shows the selected clock, never the inverted one
      n.prev_clk = gclk;
      n.clk_oe = clock_output_select == ssr_pkg::CKOUT_CONT ||
                 clock_output_select == ssr_pkg::CKOUT_XFER;
      case (clock_output_select)
         ssr_pkg::CKOUT_CONT: n.clk_o = src_clk;
         ssr_pkg::CKOUT_XFER: n.clk_o = src_clk & (r.st == ssr_pkg::ST_DATA);
         default: n.clk_o = 1'b0;
      endcase
      // sampling edge: sync, compare hunt and the receive sequence
      if (s_edge) begin
         n.sync_p = r.sync_q;
         n.sync_q = sync_in;
         n.hunt = hunt_n;
         n.tx_pend = 1'b0;
         if (sync_edge_select ? (r.sync_q & ~sync_in) : (~r.sync_q & sync_in)) begin
            n.sync_flag = 1'b1;
         end
         if (start_sel == ssr_pkg::START_CMP0 && stop_sel && cmp1_hit) begin
            n.cmp1_seen = 1'b1;
         end
         case (r.st)
            ssr_pkg::ST_IDLE: begin
               // a zero word length is refused, the receiver stays idle
               if (r.enable && go && word_length != 5'h00) begin
                  n.sync_hold = hunt_n & cmp_mask;
                  n.toggle = ~r.toggle;
                  n.cmp1_seen = 1'b0;
                  n.pulse_req = period == 8'h00;
                  n.bit_cnt = 5'h00;
                  n.word_cnt = 4'h0;
                  n.dly = 8'h00;
                  n.st = start_delay != 8'h00 ? ssr_pkg::ST_DELAY
                                              : ssr_pkg::ST_DATA;
               end
            end
            ssr_pkg::ST_DELAY: begin
               if (r.dly == start_delay - 8'h01) begin
                  n.st = ssr_pkg::ST_DATA;
               end else begin
                  n.dly = r.dly + 8'h01;
               end
            end
            ssr_pkg::ST_DATA: begin
               n.shreg = r.bit_cnt == 5'h00 ? 32'h00000000 : r.shreg;
               if (bit_order) begin
                  n.shreg = {n.shreg[30:0], din};
               end else begin
                  n.shreg[r.bit_cnt] = din;
               end
               n.bit_cnt = r.bit_cnt + 5'h01;
               if (r.bit_cnt == word_length) begin
                  n.bit_cnt = 5'h00;
                  n.word = n.shreg;
                  n.word_valid = 1'b1;
                  n.word_cnt = r.word_cnt + 4'h1;
                  if (r.word_cnt == words_per_frame) begin
                     n.word_cnt = 4'h0;
                     // continuous start, or compare run waiting for compare 1
                     if (!(start_sel == ssr_pkg::START_CONT ||
                           (start_sel == ssr_pkg::START_CMP0 && stop_sel
                            && !n.cmp1_seen))) begin
                        n.st = ssr_pkg::ST_IDLE;
                     end
                  end
                  // disable lands at a word boundary, never mid word
                  if (!r.enable) begin
                     n.st = ssr_pkg::ST_IDLE;
                  end
               end
            end
            default: n.st = ssr_pkg::ST_IDLE;
         endcase
      end
      // set wins over consumption in the same cycle
      if (tx_start) begin
         n.tx_pend = 1'b1;
      end
      // driving edge: periodic sync, pulse shaping and sync pin
      if (d_edge) begin
         n.pulse_req = 1'b0;
         n.per_cnt = 9'h000;
         if (period != 8'h00 && r.per_cnt < {period, 1'b1}) begin
            n.per_cnt = r.per_cnt + 9'h001;
         end
         // >= keeps a shrunken period from letting the counter run away
         if ((period != 8'h00 && r.per_cnt >= {period, 1'b1}) || r.pulse_req) begin
            n.pulse_on = 1'b1;
            n.pulse_cnt = sync_length;
         end else if (r.pulse_on) begin
            if (r.pulse_cnt == 8'h00) begin
               n.pulse_on = 1'b0;
            end else begin
               n.pulse_cnt = r.pulse_cnt - 8'h01;
            end
         end
         case (sync_output_select)
            ssr_pkg::SOUT_NEG: n.sync_o = ~n.pulse_on;
            ssr_pkg::SOUT_POS: n.sync_o = n.pulse_on;
            ssr_pkg::SOUT_LOW: n.sync_o = r.st != ssr_pkg::ST_DATA;
            ssr_pkg::SOUT_HIGH: n.sync_o = r.st == ssr_pkg::ST_DATA;
            ssr_pkg::SOUT_TOGGLE: n.sync_o = r.toggle;
            default: n.sync_o = 1'b0;
         endcase
      end
      // a shortened sync length cuts a running pulse down at once
      if (n.pulse_cnt > sync_length) begin
         n.pulse_cnt = sync_length;
      end
      n.sync_oe = sync_output_select >= ssr_pkg::SOUT_NEG &&
                  sync_output_select <= ssr_pkg::SOUT_TOGGLE;
   end

   // single state register, all zero after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // every output straight from the state register
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign rx_clk_drv = r.clk_o;
   assign rx_clk_oe = r.clk_oe;
   assign rx_sync_drv = r.sync_o;
   assign rx_sync_oe = r.sync_oe;
   assign rx_word = r.word;
   assign rx_word_valid = r.word_valid;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_word_end;
      s_edge && r.st == ssr_pkg::ST_DATA && r.bit_cnt == word_length;
   endsequence
   sequence s_frame_end;
      s_word_end ##0 r.word_cnt == words_per_frame;
   endsequence

   word_bits_a: assert property (s_word_end |=> rx_word_valid)
      else $error("word not delivered after its last bit");
   bit_bound_a: assert property (r.st == ssr_pkg::ST_DATA |-> r.bit_cnt <= word_length)
      else $error("bit count ran past the word length");
   frame_words_a: assert property (r.word_cnt <= words_per_frame || $changed(r.rxfrm)
      || $past(r.st) == ssr_pkg::ST_IDLE)
      else $error("word count ran past the frame size");
   one_shot_a: assert property (s_frame_end ##0 start_sel == ssr_pkg::START_CMP0
      && !stop_sel |=> r.st == ssr_pkg::ST_IDLE)
      else $error("compare start did not stop after its frame");
   delay_len_a: assert property (r.st == ssr_pkg::ST_DELAY && $stable(start_delay)
      |-> r.dly < start_delay)
      else $error("start delay counter ran past the delay");
   reserved_start_a: assert property (r.st == ssr_pkg::ST_IDLE && start_sel >
      ssr_pkg::START_CMP0 |=> r.st == ssr_pkg::ST_IDLE)
      else $error("reserved start code started reception");
   zero_len_a: assert property (r.st == ssr_pkg::ST_IDLE && word_length == 5'h00
      |=> r.st == ssr_pkg::ST_IDLE)
      else $error("zero word length started reception");
   pulse_len_a: assert property (r.pulse_on && $stable(sync_length)
      |-> r.pulse_cnt <= sync_length)
      else $error("sync pulse longer than sync length plus one");
   period_a: assert property (period != 8'h00 && $stable(period)
      |-> r.per_cnt <= {period, 1'b1})
      else $error("frame sync period counter out of range");
   xfer_clock_a: assert property (clock_output_select == ssr_pkg::CKOUT_XFER
      && r.st != ssr_pkg::ST_DATA |=> !rx_clk_drv && rx_clk_oe)
      else $error("clock pin driven outside a transfer");
   sync_flag_a: assert property (s_edge && !sync_edge_select && !r.sync_q && sync_in
      |=> r.sync_flag)
      else $error("rising sync edge did not set the flag");
   apb_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("apb access not answered after one wait state");
endmodule

// [dv/ssr_peer.sv]
// serial peer model driving the receive clock pin and data line
`timescale 1ns/1ps
module ssr_peer (
   // system clock
   input wire logic clk,
   // link lines
   output logic pin_clk,
   output logic pin_data
);
   // clock idles low between frames
   initial begin
      pin_clk = 1'b0;
      pin_data = 1'b0;
   end
   // data launched at the rising edge so it is steady at the sampling edge
   task automatic send_bit(input logic b, input int half);
      pin_data <= b;
      pin_clk <= 1'b1;
      repeat (half) @(posedge clk);
      pin_clk <= 1'b0;
      repeat (half) @(posedge clk);
   endtask
   // a released line shows the inverse of its last bit, never a held value
   task automatic release_line();
      pin_data <= ~pin_data;
   endtask
endmodule

// [dv/ssr_rx_core_tb.sv]
// self-checking bench for the sync serial receive path
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module ssr_rx_core_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [31:0] rx_word;
   logic [31:0] exp_word = 32'h00000000;
   logic [15:0] cmp0 = 16'h0000;
   logic [15:0] cmp1 = 16'h0000;
   logic pready;
   logic pslverr;
   logic err;
   logic ck_drv;
   logic ck_oe;
   logic sync_drv;
   logic sync_oe;
   logic peer_clk;
   logic peer_data;
   logic tx_clk = 1'b0;
   logic rx_word_valid;
   int num_errors = 0;
   int checks_done = 0;
   int n_words = 0;
   // system clock and a free-running transmit clock stand-in
   always #5 clk = ~clk;
   always @(posedge clk) tx_clk <= ~tx_clk;
   ssr_peer peer_i (.clk(clk), .pin_clk(peer_clk), .pin_data(peer_data));
   ssr_rx_core ssr_rx_core_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_clk_pin(ck_oe ? ck_drv : peer_clk), .rx_clk_drv(ck_drv),
      .rx_clk_oe(ck_oe), .rx_sync_pin(1'b0), .rx_sync_drv(sync_drv), .rx_sync_oe(sync_oe),
      .rx_data(peer_data), .tx_clk(tx_clk), .tx_sync(1'b0), .tx_data(1'b0),
      .tx_start(1'b0), .cmp0(cmp0), .cmp1(cmp1), .rx_word(rx_word),
      .rx_word_valid(rx_word_valid));
   // every new word must equal the one the peer sent
   always @(posedge clk) begin
      if (rx_word_valid === 1'b1) begin
         n_words++;
         `CHK(rx_word, exp_word)
      end
   end
   // one apb transfer; entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // the slave sets the pace; only the watchdog ends a hung wait
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // reset value, then only the writable bits stick
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] m);
      logic [31:0] v;
      v = $urandom;
      apb(1'b0, a, 32'h0);
      `CHK(rd, ssr_pkg::REG_RESET)
      apb(1'b1, a, v);
      apb(1'b0, a, 32'h0);
      `CHK(rd, v & m)
   endtask
   // spacing of clock pin changes; zero when it never moves
   task automatic edge_gap(output int gap);
      logic prev;
      int last;
      int seen;
      gap = 0;
      seen = 0;
      last = 0;
      prev = ck_drv;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         if (ck_drv !== prev) begin
            seen++;
            gap = i - last;
            last = i;
         end
         prev = ck_drv;
      end
      if (seen < 3) gap = 0;
   endtask
   // continuous or compare 0 start from the clock pin; leading bits are start and delay
   task automatic frame(input int dly, input int len, input int w, input logic msb,
      input int half, input logic cmp);
      logic [31:0] v;
      v = $urandom;
      if (len < 31) v = v & ((32'h1 << (len + 1)) - 32'h1);
      exp_word = v;
      n_words = 0;
      // sync pin set to go high during transfers
      apb(1'b1, ssr_pkg::OFF_RXFRM, 32'(len) | (32'(msb) << 7) | (32'(w) << 8)
         | 32'h00400000);
      apb(1'b1, ssr_pkg::OFF_RXCLK, (32'(dly) << 16) | (32'(cmp) << 11) | 32'h2);
      apb(1'b1, ssr_pkg::OFF_CTRL, 32'h1);
      // sync length zero: compare 0 looks at the last sampled bit only
      if (cmp) peer_i.send_bit(cmp0[0], half);
      repeat (cmp ? dly : dly + 1) peer_i.send_bit(1'($urandom), half);
      for (int k = 0; k <= w; k++) begin
         for (int b = 0; b <= len; b++) peer_i.send_bit(msb ? v[len - b] : v[b], half);
      end
      peer_i.release_line();
      repeat (12) @(posedge clk);
      `CHK(n_words, w + 1)
      `CHK({sync_oe, sync_drv}, 2'b11)
      if (cmp) begin
         // no new compare match: the receiver must stay stopped
         repeat (len + 1) peer_i.send_bit(~cmp0[0], half);
         repeat (12) @(posedge clk);
         `CHK(n_words, w + 1)
         `CHK(sync_drv, 1'b0)
      end
      apb(1'b1, ssr_pkg::OFF_CTRL, 32'h0);
      // continuous reception only stops at a word end, so finish one more word
      if (!cmp) begin
         for (int b = 0; b <= len; b++) peer_i.send_bit(msb ? v[len - b] : v[b], half);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // watchdog at about four times the longest possible run
   initial begin
      #200000;
      num_errors++;
      final_report();
   end
   initial begin
      int gap;
      int d;
      void'($urandom(32'hACC5));
      cmp0 <= 16'($urandom);
      cmp1 <= 16'($urandom);
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reg_chk(ssr_pkg::OFF_CLKDIV, ssr_pkg::MASK_CLKDIV);
      reg_chk(ssr_pkg::OFF_RXCLK, ssr_pkg::MASK_RXCLK);
      reg_chk(ssr_pkg::OFF_RXFRM, ssr_pkg::MASK_RXFRM);
      apb(1'b0, 8'h08, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h00000000)
      // divided clock on the pin, inversion alternating, zero divider first
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 0 : $urandom_range(6, 1);
         apb(1'b1, ssr_pkg::OFF_CLKDIV, 32'(d));
         apb(1'b1, ssr_pkg::OFF_RXCLK, 32'h4 | (32'(i & 1) << 5));
         edge_gap(gap);
         `CHK(gap, d)
         `CHK(ck_oe, 1'b1)
      end
      apb(1'b1, ssr_pkg::OFF_RXCLK, 32'h2);
      @(posedge clk);
      `CHK(ck_oe, 1'b0)
      frame(0, 31, 1, 1'b1, 3, 1'b0);
      frame(255, 7, 0, 1'b0, 3, 1'b1);
      for (int k = 0; k < 6; k++) begin
         frame($urandom_range(3, 0), $urandom_range(7, 1), $urandom_range(2, 0),
            1'($urandom), $urandom_range(5, 3), 1'($urandom));
      end
      final_report();
   end
endmodule
